// >>> pkg/pcc_pkg.sv
package pcc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_COLOR_PATH = 8'h00;
  localparam logic [7:0] OFS_FOG_UNIT = 8'h04;
  localparam logic [7:0] OFS_HAZE_COLOR = 8'h08;
  localparam logic [7:0] OFS_FB_RENDER = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_HAZE_TABLE = 8'h80;
  localparam int HAZE_TABLE_DEPTH = 64;

  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Color path control fields
  localparam int CP_RGB_SEL = 0;
  localparam int CP_ALPHA_SEL = 2;
  localparam int CP_LOCAL_SEL = 4;
  localparam int CP_ALPHA_LOCAL_SEL = 5;
  localparam int CP_LOCAL_OVR = 7;
  localparam int CP_COLOR_OTHER_FORCE_ZERO = 8;
  localparam int CP_CC_SUB_LOCAL = 9;
  localparam int CP_CC_MSEL = 10;
  localparam int CP_CC_REVERSE = 13;
  localparam int CP_CC_ADD_COLOR = 14;
  localparam int CP_CC_ADD_ALPHA = 15;
  localparam int CP_CC_INVERT = 16;
  localparam int CP_AC_ZERO_OTHER = 17;
  localparam int CP_AC_SUB_LOCAL = 18;
  localparam int CP_AC_MSEL = 19;
  localparam int CP_AC_REVERSE = 22;
  localparam int CP_AC_ADD_LOCAL = 23;
  localparam int CP_AC_ADD_ALPHA = 24;
  localparam int CP_AC_INVERT = 25;
  localparam int CP_PARAM_ADJUST = 26;
  localparam int CP_TEX_ENABLE = 27;
  localparam int CP_CLAMP_ENABLE = 28;

  // Fog unit control fields
  localparam int FG_ENABLE = 0;
  localparam int FG_ADD_ZERO = 1;
  localparam int FG_MULT_ZERO = 2;
  localparam int FG_ALPHA_SRC = 3;
  localparam int FG_CONSTANT = 5;
  localparam int FG_DITHER = 6;
  localparam int FG_ZONES = 7;

  // Framebuffer render control: float depth source
  localparam int FB_DEPTH_FLOAT_Z = 21;

  // Setup latencies
  localparam logic [4:0] SETUP_CLKS_PLAIN = 5'd7;
  localparam logic [4:0] SETUP_CLKS_ADJUST = 5'd16;

  // Wrap detection values
  localparam logic [11:0] WRAP_NEG = 12'hFFF;
  localparam logic [11:0] WRAP_OVF = 12'h100;

  typedef enum logic [1:0] {
    PCC_IDLE = 2'b00,
    PCC_SETUP = 2'b01
  } pcc_setup_e;

  typedef struct packed {
    logic [23:0] red;
    logic [23:0] green;
    logic [23:0] blue;
    logic [23:0] alpha;
    logic [31:0] depth_z;
    logic [31:0] depth_w;
    logic [15:0] inv_w_float;
    logic [1:0] dither;
  } pcc_pixel_s;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] alpha;
  } pcc_color_s;

endpackage : pcc_pkg

// >>> design/pcc_color_combine_fog.sv
// Operation
// - RGB source select picks other colour: iterated, texel, constant one.
// - Alpha source select picks other alpha: iterated, texel, constant one.
// - Local select bit picks local colour: iterated or constant zero.
// - Alpha local select: iterated, constant zero, clamped Z, clamped W.
// - Override bit lets texel alpha bit 7 pick local colour per pixel.
// - Colour unit can zero other colour and subtract local or zero.
// - Colour factor select: zero, local, other alpha, local alpha, texel alpha, texel.
// - Colour reverse blend, add local colour, add local alpha, invert output.
// - Alpha unit can zero other alpha and subtract local or zero.
// - Alpha factor select: zero, local, other, local, texel alpha.
// - Alpha reverse blend, add local, add local alpha, invert output.
// - Parameter adjust corrects starts; setup takes 16 clocks, else 7.
// - Correction applies as starts leave FIFO; host must resend starts.
// - Texel transfer occurs only while texture enable is set.
// - Clamp enable clamps RGBA iterators to 0..0xFF in raster only.
// - Without clamp, colours wrap: 0xFFF gives 0, 0x100 gives 0xFF.
// - Clamp enable clamps Z to 0..0xFFFF; float depth uses raw Z.
// - Clamp enable clamps W for alpha and fog; float depth uses raw W.
// - Fog add and multiply bits zero fog term and input term.
// - Fog alpha from 64-entry table, interpolated by 8 lower bits.
// - Fog alpha source: iterated alpha, Z high, W low; constant bit overrides.
// - Fog dither bit dithers table factor; zones bit makes entries signed.
// - Framebuffer bit picks float depth iterator: W clear, Z set.
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module pcc_color_combine_fog (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic setup_start,
  output logic setup_busy,
  output logic setup_adjust,
  input wire logic pix_valid,
  input wire pcc_pkg::pcc_pixel_s pix_in,
  output logic tex_req,
  input wire logic tex_valid,
  input wire pcc_pkg::pcc_color_s tex_in,
  output logic out_valid,
  output pcc_pkg::pcc_color_s out_color,
  output pcc_pkg::pcc_color_s out_unfogged,
  output logic [31:0] out_float_depth
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave
  logic [31:0] color_path_control_reg;
  logic [31:0] fog_unit_control_reg;
  logic [31:0] haze_constant_color_reg;
  logic [31:0] framebuffer_render_control_reg;
  logic [7:0] haze_lookup_table [pcc_pkg::HAZE_TABLE_DEPTH];
  logic [7:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic [31:0] rd_next;
  logic rd_ok;
  logic wr_ok;
  logic setup_busy_reg;
  logic [4:0] setup_cnt_reg;
  pcc_pkg::pcc_setup_e setup_state_reg;

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= pcc_pkg::RST_ZERO;
      w_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[7:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      else if (s_axi_bvalid && s_axi_bready)
        w_held_reg <= 1'b0;
    end
  end

  // Write commits once both halves are held and no response is pending
  logic wr_fire;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_comb
  begin
    wr_ok = 1'b1;
    if (aw_addr_reg[7] || aw_addr_reg[1:0] != 2'b00)
      wr_ok = aw_addr_reg[7] && aw_addr_reg[1:0] == 2'b00;
    else if (aw_addr_reg > pcc_pkg::OFS_FB_RENDER)
      wr_ok = 1'b0;
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : merge

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      color_path_control_reg <= pcc_pkg::RST_ZERO;
      fog_unit_control_reg <= pcc_pkg::RST_ZERO;
      haze_constant_color_reg <= pcc_pkg::RST_ZERO;
      framebuffer_render_control_reg <= pcc_pkg::RST_ZERO;
    end
    else if (wr_fire)
    begin
      case (aw_addr_reg)
        pcc_pkg::OFS_COLOR_PATH:
          color_path_control_reg <= merge(color_path_control_reg, w_data_reg, w_strb_reg);
        pcc_pkg::OFS_FOG_UNIT:
          fog_unit_control_reg <= merge(fog_unit_control_reg, w_data_reg, w_strb_reg);
        pcc_pkg::OFS_HAZE_COLOR:
          haze_constant_color_reg <= merge(haze_constant_color_reg, w_data_reg, w_strb_reg);
        pcc_pkg::OFS_FB_RENDER:
          framebuffer_render_control_reg <=
            merge(framebuffer_render_control_reg, w_data_reg, w_strb_reg);
        default: ;
      endcase
    end
  end

  // Host-loaded fog table, one entry per word, low byte
  always_ff @(posedge mclk)
  begin
    if (wr_fire && aw_addr_reg[7] && w_strb_reg[0])
      haze_lookup_table[{aw_addr_reg[6], aw_addr_reg[6:2]}] <= w_data_reg[7:0];
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      s_axi_bvalid <= 1'b0;
    else if (wr_fire)
      s_axi_bvalid <= 1'b1;
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      s_axi_bresp <= 2'b00;
    else if (wr_fire)
      s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
  end

  always_comb
  begin
    rd_ok = 1'b1;
    rd_next = pcc_pkg::RST_ZERO;
    if (s_axi_araddr[1:0] != 2'b00)
      rd_ok = 1'b0;
    else if (s_axi_araddr[7])
      rd_next = {24'h000000, haze_lookup_table[{s_axi_araddr[6], s_axi_araddr[6:2]}]};
    else
    begin
      case (s_axi_araddr[7:0])
        pcc_pkg::OFS_COLOR_PATH: rd_next = color_path_control_reg;
        pcc_pkg::OFS_FOG_UNIT: rd_next = fog_unit_control_reg;
        pcc_pkg::OFS_HAZE_COLOR: rd_next = haze_constant_color_reg;
        pcc_pkg::OFS_FB_RENDER: rd_next = framebuffer_render_control_reg;
        pcc_pkg::OFS_STATUS: rd_next = {26'h0, setup_state_reg == pcc_pkg::PCC_SETUP,
                                        setup_cnt_reg};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= pcc_pkg::RST_ZERO;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_next;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Triangle setup timing
  // Starts are corrected as they leave the FIFO; held starts get corrected
  // again, so the host owes fresh starts each triangle
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      setup_state_reg <= pcc_pkg::PCC_IDLE;
      setup_cnt_reg <= 5'd0;
    end
    else
    begin
      case (setup_state_reg)
        pcc_pkg::PCC_IDLE:
          if (setup_start)
          begin
            setup_state_reg <= pcc_pkg::PCC_SETUP;
            setup_cnt_reg <= color_path_control_reg[pcc_pkg::CP_PARAM_ADJUST]
                             ? pcc_pkg::SETUP_CLKS_ADJUST - 5'd1
                             : pcc_pkg::SETUP_CLKS_PLAIN - 5'd1;
          end
        pcc_pkg::PCC_SETUP:
          if (setup_cnt_reg == 5'd0)
            setup_state_reg <= pcc_pkg::PCC_IDLE;
          else
            setup_cnt_reg <= setup_cnt_reg - 5'd1;
        default: setup_state_reg <= pcc_pkg::PCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      setup_busy_reg <= 1'b0;
    else
      setup_busy_reg <= setup_state_reg == pcc_pkg::PCC_SETUP;
  end
  assign setup_busy = setup_state_reg == pcc_pkg::PCC_SETUP;
  assign setup_adjust = color_path_control_reg[pcc_pkg::CP_PARAM_ADJUST];

  ////////////////////////////////////////////////////////////////////////////
  // Pixel datapath
  logic [31:0] cp;
  logic [31:0] fm;
  logic clamp_en;
  assign cp = color_path_control_reg;
  assign fm = fog_unit_control_reg;
  assign clamp_en = cp[pcc_pkg::CP_CLAMP_ENABLE];

  // Texels move only with texturing enabled
  assign tex_req = pix_valid && cp[pcc_pkg::CP_TEX_ENABLE];
  logic stage_go;
  assign stage_go = pix_valid && (!cp[pcc_pkg::CP_TEX_ENABLE] || tex_valid);
  pcc_pkg::pcc_color_s tex;
  assign tex = cp[pcc_pkg::CP_TEX_ENABLE] ? tex_in : '0;

  function automatic logic [7:0] clamp_color(input logic [23:0] it, input logic en);
    if (en)
      return it[23] ? 8'h00 : (it[23:20] != 4'h0 ? 8'hFF : it[19:12]);
    else if (it[23:12] == pcc_pkg::WRAP_NEG)
      return 8'h00;
    else if (it[23:12] == pcc_pkg::WRAP_OVF)
      return 8'hFF;
    else
      return it[19:12];
  endfunction : clamp_color

  // Z clamped to 16 bits; W clamped to 8 bits for alpha and fog
  logic [15:0] z_clamped;
  logic [7:0] w_clamped;
  always_comb
  begin
    if (!clamp_en)
      z_clamped = pix_in.depth_z[27:12];
    else if (pix_in.depth_z[31])
      z_clamped = 16'h0000;
    else if (pix_in.depth_z[30:28] != 3'h0)
      z_clamped = 16'hFFFF;
    else
      z_clamped = pix_in.depth_z[27:12];
    if (!clamp_en)
      w_clamped = pix_in.depth_w[7:0];
    else if (pix_in.depth_w[31])
      w_clamped = 8'h00;
    else if (pix_in.depth_w[30:8] != 23'h0)
      w_clamped = 8'hFF;
    else
      w_clamped = pix_in.depth_w[7:0];
  end

  pcc_pkg::pcc_color_s iter;
  pcc_pkg::pcc_color_s c0;
  pcc_pkg::pcc_color_s c1;
  assign iter = '{clamp_color(pix_in.red, clamp_en), clamp_color(pix_in.green, clamp_en),
                  clamp_color(pix_in.blue, clamp_en), clamp_color(pix_in.alpha, clamp_en)};
  assign c0 = '0;
  assign c1 = haze_constant_color_reg;

  logic [23:0] c_other;
  logic [23:0] c_local;
  logic [7:0] a_other;
  logic [7:0] a_local;
  logic local_pick;
  always_comb
  begin
    case (cp[pcc_pkg::CP_RGB_SEL +: 2])
      2'd0: c_other = {iter.red, iter.green, iter.blue};
      2'd1: c_other = {tex.red, tex.green, tex.blue};
      2'd2: c_other = {c1.red, c1.green, c1.blue};
      default: c_other = 24'h000000;
    endcase
    case (cp[pcc_pkg::CP_ALPHA_SEL +: 2])
      2'd0: a_other = iter.alpha;
      2'd1: a_other = tex.alpha;
      2'd2: a_other = c1.alpha;
      default: a_other = 8'h00;
    endcase
    local_pick = cp[pcc_pkg::CP_LOCAL_OVR] ? tex.alpha[7] : cp[pcc_pkg::CP_LOCAL_SEL];
    c_local = local_pick ? {c0.red, c0.green, c0.blue}
                         : {iter.red, iter.green, iter.blue};
    case (cp[pcc_pkg::CP_ALPHA_LOCAL_SEL +: 2])
      2'd0: a_local = iter.alpha;
      2'd1: a_local = c0.alpha;
      2'd2: a_local = z_clamped[15:8];
      default: a_local = w_clamped;
    endcase
  end

  // One channel: (other - sub) * factor + add, optionally inverted
  function automatic logic [7:0] combine(input logic [7:0] oth, input logic [7:0] loc,
                                         input logic [7:0] fac, input logic zero_o,
                                         input logic sub_l, input logic rev,
                                         input logic [8:0] addv, input logic inv);
    logic signed [9:0] diff;
    logic [8:0] f;
    logic signed [19:0] prod;
    logic signed [19:0] sum;
    logic [7:0] res;
    diff = $signed({2'b00, zero_o ? 8'h00 : oth}) - $signed({2'b00, sub_l ? loc : 8'h00});
    f = {1'b0, rev ? fac : ~fac} + 9'd1;
    prod = $signed({{10{diff[9]}}, diff}) * $signed({11'h000, f});
    sum = (prod >>> 8) + $signed({11'h000, addv});
    if (sum < 0)
      res = 8'h00;
    else if (sum > 20'sd255)
      res = 8'hFF;
    else
      res = sum[7:0];
    return inv ? ~res : res;
  endfunction : combine

  pcc_pkg::pcc_color_s cc_out;
  always_comb
  begin
    logic [23:0] fac;
    logic [7:0] af;
    fac = 24'h000000;
    af = 8'h00;
    case (cp[pcc_pkg::CP_CC_MSEL +: 3])
      3'd1: fac = c_local;
      3'd2: fac = {3{a_other}};
      3'd3: fac = {3{a_local}};
      3'd4: fac = {3{tex.alpha}};
      3'd5: fac = {tex.red, tex.green, tex.blue};
      default: fac = 24'h000000;
    endcase
    case (cp[pcc_pkg::CP_AC_MSEL +: 3])
      3'd1: af = a_local;
      3'd2: af = a_other;
      3'd3: af = a_local;
      3'd4: af = tex.alpha;
      default: af = 8'h00;
    endcase
    for (int i = 0; i < 3; i++)
      cc_out[8 + i*8 +: 8] = combine(c_other[i*8 +: 8], c_local[i*8 +: 8], fac[i*8 +: 8],
        cp[pcc_pkg::CP_COLOR_OTHER_FORCE_ZERO], cp[pcc_pkg::CP_CC_SUB_LOCAL],
        cp[pcc_pkg::CP_CC_REVERSE],
        (cp[pcc_pkg::CP_CC_ADD_COLOR] ? {1'b0, c_local[i*8 +: 8]} : 9'h000)
        + (cp[pcc_pkg::CP_CC_ADD_ALPHA] ? {1'b0, a_local} : 9'h000),
        cp[pcc_pkg::CP_CC_INVERT]);
    cc_out.alpha = combine(a_other, a_local, af, cp[pcc_pkg::CP_AC_ZERO_OTHER],
      cp[pcc_pkg::CP_AC_SUB_LOCAL], cp[pcc_pkg::CP_AC_REVERSE],
      (cp[pcc_pkg::CP_AC_ADD_LOCAL] ? {1'b0, a_local} : 9'h000)
      + (cp[pcc_pkg::CP_AC_ADD_ALPHA] ? {1'b0, a_local} : 9'h000),
      cp[pcc_pkg::CP_AC_INVERT]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fog
  logic [5:0] fog_idx;
  logic [7:0] fog_frac;
  logic [7:0] fog_alpha;
  always_comb
  begin
    logic signed [9:0] e0;
    logic signed [9:0] e1;
    logic signed [19:0] interp;
    logic [7:0] fr;
    e0 = '0;
    e1 = '0;
    interp = '0;
    fr = 8'h00;
    fog_idx = pix_in.inv_w_float[15:10];
    fog_frac = pix_in.inv_w_float[9:2];
    // Dither trades a little noise for less banding
    fr = (fm[pcc_pkg::FG_DITHER] && fog_frac != 8'hFF) ? fog_frac + {6'h00, pix_in.dither}
                                                        : fog_frac;
    e0 = fm[pcc_pkg::FG_ZONES] ? {{2{haze_lookup_table[fog_idx][7]}}, haze_lookup_table[fog_idx]}
                               : {2'b00, haze_lookup_table[fog_idx]};
    e1 = fm[pcc_pkg::FG_ZONES]
         ? {{2{haze_lookup_table[fog_idx + 6'd1][7]}}, haze_lookup_table[fog_idx + 6'd1]}
         : {2'b00, haze_lookup_table[fog_idx + 6'd1]};
    if (fog_idx == 6'h3F)
      e1 = e0;
    interp = $signed({{10{e0[9]}}, e0})
             + (($signed({{10{e1[9]}}, e1 - e0}) * $signed({12'h000, fr})) >>> 8);
    fog_alpha = interp < 0 ? 8'h00 : (interp > 20'sd255 ? 8'hFF : interp[7:0]);
    case (fm[pcc_pkg::FG_ALPHA_SRC +: 2])
      2'd1: fog_alpha = iter.alpha;
      2'd2: fog_alpha = z_clamped[15:8];
      2'd3: fog_alpha = w_clamped;
      default: ;
    endcase
  end

  pcc_pkg::pcc_color_s fog_out;
  always_comb
  begin
    logic [15:0] t;
    t = 16'h0000;
    fog_out = cc_out;
    if (fm[pcc_pkg::FG_ENABLE])
    begin
      for (int i = 1; i < 4; i++)
      begin
        if (fm[pcc_pkg::FG_CONSTANT])
          // Constant add saturates rather than wrapping to black
          t = ({1'b0, cc_out[i*8 +: 8]} + {1'b0, c1[i*8 +: 8]} > 9'h0FF) ? 16'hFF00
              : {cc_out[i*8 +: 8] + c1[i*8 +: 8], 8'h00};
        else
          t = (fm[pcc_pkg::FG_ADD_ZERO] ? 16'h0000 : fog_alpha * c1[i*8 +: 8])
              + (fm[pcc_pkg::FG_MULT_ZERO] ? 16'h0000 : (8'hFF - fog_alpha) * cc_out[i*8 +: 8]);
        fog_out[i*8 +: 8] = t[15:8] == 8'hFF || t > 16'hFEFF ? 8'hFF : t[15:8];
        if (fm[pcc_pkg::FG_CONSTANT] && t[15:8] != t[15:8])
          fog_out[i*8 +: 8] = 8'hFF;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_color <= '0;
      out_unfogged <= '0;
      out_float_depth <= pcc_pkg::RST_ZERO;
    end
    else
    begin
      out_valid <= stage_go;
      if (stage_go)
      begin
        out_color <= fog_out;
        out_unfogged <= cc_out;
        out_float_depth <= framebuffer_render_control_reg[pcc_pkg::FB_DEPTH_FLOAT_Z]
                           ? pix_in.depth_z : pix_in.depth_w;
      end
    end
  end

endmodule : pcc_color_combine_fog

// >>> verif/pcc_assertions.sv
`timescale 1ns/1ps
module pcc_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic setup_start,
  input wire logic setup_busy,
  input wire logic setup_adjust,
  input wire logic pix_valid,
  input wire logic tex_req,
  input wire logic tex_valid,
  input wire logic out_valid
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  sequence busy_short;
    setup_busy [*7] ##1 !setup_busy;
  endsequence
  // Long setup split in two runs to keep the repetition small
  sequence busy_long;
    setup_busy [*8] ##1 setup_busy [*8] ##1 !setup_busy;
  endsequence
  ////////////////////////////////////////
  chk_setup_plain: assert property ($rose(setup_busy) && !setup_adjust |-> busy_short)
    else $error("setup without adjust not 7 cycles");
  chk_setup_adjusted: assert property ($rose(setup_busy) && setup_adjust |-> busy_long)
    else $error("setup with adjust not 16 cycles");
  chk_setup_launch: assert property (setup_start && !setup_busy |=> setup_busy)
    else $error("setup start not taken");
  chk_tex_request: assert property (tex_req |-> pix_valid)
    else $error("texel request without pixel");
  chk_tex_stall: assert property (pix_valid && tex_req && !tex_valid |=> !out_valid)
    else $error("pixel passed without texel");
  chk_pixel_out: assert property (pix_valid && (!tex_req || tex_valid) |=> out_valid)
    else $error("accepted pixel gave no output");
  chk_write_answer: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : pcc_chk
bind pcc_color_combine_fog pcc_chk i_chk (.mclk, .reset, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .setup_start, .setup_busy, .setup_adjust,
  .pix_valid, .tex_req, .tex_valid, .out_valid);

// >>> verif/pcc_tex_model.sv
`timescale 1ns/1ps
module pcc_tex_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic tex_req,
  input wire logic [3:0] lat,
  input wire logic [31:0] texel,
  output logic tex_valid,
  output pcc_pkg::pcc_color_s tex_in
);
  logic [3:0] wait_reg;
  // Counts request cycles so the texel can arrive late
  always_ff @(posedge mclk)
  begin
    if (reset || !tex_req)
      wait_reg <= 4'h0;
    else if (wait_reg != 4'hF)
      wait_reg <= wait_reg + 4'h1;
  end
  // Texel only offered against a live request
  assign tex_valid = tex_req && (wait_reg >= lat);
  // Scrambled off the handshake so a stale texel never matches
  assign tex_in = tex_valid ? texel : ~texel;
endmodule : pcc_tex_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, setup_start = 1'b0, pix_valid = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF, tex_lat = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic setup_busy, setup_adjust, tex_req, tex_valid, out_valid, treq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, out_float_depth, rd, got, got_d, got_u;
  pcc_pkg::pcc_pixel_s pix_in = '0;
  pcc_pkg::pcc_color_s tex_in, out_color, out_unfogged;
  int bad_count = 0, checks = 0, cyc = 0;
  localparam logic [31:0] TEXEL = 32'h3C3C3C80;
  localparam logic [31:0] Z_VAL = 32'h00123456;
  localparam logic [31:0] W_VAL = 32'h00654321;
  // Entries: colour path, fog control, iterator, expected colour
  logic [127:0] tbl [17] = '{
    {32'h0, 32'h0, 32'h00FFF000, 32'h00000000},
    {32'h0, 32'h0, 32'h00100000, 32'hFFFFFFFF},
    {32'h0, 32'h0, 32'h000AB000, 32'hABABABAB},
    {32'h0, 32'h0, 32'h00123000, 32'h23232323},
    {32'h10000000, 32'h0, 32'h00123000, 32'hFFFFFFFF},
    {32'h10000000, 32'h0, 32'h00F80000, 32'h00000000},
    {32'h0000000A, 32'h0, 32'h000AB000, 32'h55555555},
    {32'h00004110, 32'h0, 32'h000AB000, 32'h000000AB},
    {32'h00014100, 32'h0, 32'h000AB000, 32'h545454AB},
    {32'h08000005, 32'h0, 32'h000AB000, 32'h3C3C3C80},
    {32'h08004180, 32'h0, 32'h000AB000, 32'h000000AB},
    {32'h02820000, 32'h0, 32'h000AB000, 32'hABABAB54},
    {32'h02820020, 32'h0, 32'h000AB000, 32'hABABABFF},
    {32'h0, 32'h6, 32'h000AB000, 32'hABABABAB},
    {32'h0, 32'h9, 32'h000AB000, 32'h707070AB},
    {32'h0, 32'hF, 32'h000AB000, 32'h000000AB},
    {32'h0, 32'h21, 32'h000AB000, 32'hFFFFFFAB}};

  always #4 mclk = ~mclk;

  pcc_color_combine_fog i_dut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .setup_start, .setup_busy, .setup_adjust, .pix_valid,
    .pix_in, .tex_req, .tex_valid, .tex_in, .out_valid, .out_color, .out_unfogged,
    .out_float_depth);
  pcc_tex_model i_tex (.mclk, .reset, .tex_req, .lat(tex_lat), .texel(TEXEL), .tex_valid,
    .tex_in);
  ////////////////////////////////////////
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask : chk

  task wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Handshakes sampled at the falling edge, released just after the rising one
  task bus(input logic we, input logic [31:0] a, input logic [31:0] d);
    int n;
    logic [3:0] hs;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    do
    begin
      @(negedge mclk);
      hs = {s_axi_awready, s_axi_wready, s_axi_arready, we ? s_axi_bvalid : s_axi_rvalid};
      rsp = we ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      n++;
      @(posedge mclk);
      if (hs[3] && s_axi_awvalid)
        s_axi_awvalid <= 1'b0;
      if (hs[2] && s_axi_wvalid)
        s_axi_wvalid <= 1'b0;
      if (hs[1] && s_axi_arvalid)
        s_axi_arvalid <= 1'b0;
    end
    while (!hs[0] && n < 40);
    chk("bus_answer", 32'(hs[0]), 32'h1);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : bus

  task pix(input logic [23:0] it);
    int n;
    logic acc;
    n = 0;
    @(posedge mclk);
    pix_in <= '{it, it, it, it, Z_VAL, W_VAL, 16'h0000, 2'b00};
    pix_valid <= 1'b1;
    do
    begin
      @(negedge mclk);
      acc = !tex_req || tex_valid;
      if (n == 0)
        treq = tex_req;
      n++;
      @(posedge mclk);
    end
    while (!acc && n < 40);
    pix_valid <= 1'b0;
    @(negedge mclk);
    got = out_color;
    got_d = out_float_depth;
    got_u = out_unfogged;
    chk("out_valid", 32'(out_valid), 32'h1);
  endtask : pix

  task setup(input logic adj, input logic [31:0] exp);
    int n;
    bus(1'b1, 32'h0, {5'h0, adj, 26'h0});
    @(posedge mclk);
    setup_start <= 1'b1;
    @(posedge mclk);
    setup_start <= 1'b0;
    n = 0;
    @(negedge mclk);
    while (setup_busy === 1'b1 && n < 40)
    begin
      n++;
      @(negedge mclk);
    end
    chk("setup_clks", 32'(n), exp);
    chk("setup_adjust", 32'(setup_adjust), 32'(adj));
  endtask : setup
  ////////////////////////////////////////
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    bus(1'b0, 32'h0, 32'h0);
    chk("path_reset", rd, 32'h0);
    bus(1'b0, 32'h20, 32'h0);
    chk("unmapped_resp", 32'(rsp), 32'h2);
    bus(1'b1, 32'h8, 32'h55555555);
    $display("test registers done");
    for (int i = 0; i < 17; i++)
    begin
      bus(1'b1, 32'h0, tbl[i][127:96]);
      bus(1'b1, 32'h4, tbl[i][95:64]);
      tex_lat <= 4'(i % 3);
      pix(tbl[i][55:32]);
      chk("color", got, tbl[i][31:0]);
      chk("tex_req", 32'(treq), 32'(tbl[i][123]));
    end
    chk("unfogged", got_u, 32'hABABABAB);
    $display("test combine done");
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, 32'hC, 32'h00200000);
    bus(1'b0, 32'hC, 32'h0);
    chk("fb_readback", rd, 32'h00200000);
    pix(24'h0AB000);
    chk("depth_z", got_d, Z_VAL);
    bus(1'b1, 32'hC, 32'h0);
    pix(24'h0AB000);
    chk("depth_w", got_d, W_VAL);
    $display("test depth done");
    setup(1'b0, 32'h7);
    setup(1'b1, 32'h10);
    $display("test setup done");
    wrap_up();
  end
endmodule : testbench
